// ### hw/coherence_probe_responder.sv
// coherence probe responder: takes system coherence commands, probes caches, answers
// assumes system commands and dack are synchronous to clk and the cache ports answer as described
module coherence_probe_responder #(
  parameter int ADDR_W = 36,
  parameter int CPU_RATIO = 2,
  parameter logic [1:0] RES_NOACK = 2'h0,
  parameter logic [1:0] RES_ACK_SC = 2'h1,
  parameter logic [1:0] RES_ACK_BC = 2'h2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] sys_cmd,
  input wire logic [ADDR_W-1:0] sys_addr,
  input wire logic dev_owns_cmd_bus,
  input wire logic dack,
  input wire logic bcache_present,
  input wire logic sc_hit,
  input wire logic sc_dirty,
  input wire logic lock_hit,
  input wire logic [127:0] sc_rd_data,
  output logic [3:0] dev_cmd_out,
  output logic dev_cmd_oe_b,
  output logic cmd_overflow,
  output logic sc_probe,
  output logic [ADDR_W-1:0] probe_addr,
  output logic [1:0] sc_rd_beat,
  output logic [1:0] sc_upd_op,
  output logic res_valid,
  output logic [2:0] addr_res,
  output logic data_valid,
  output logic [127:0] data_out,
  output logic bc_rd_en,
  output logic bc_data_wr,
  output logic [ADDR_W+1:0] bc_index,
  output logic bc_tag_wr,
  output logic [1:0] bc_tag_state
);
`include "cpr_defines.svh"

  // processor cycles to whole system cycles, never under one
  // rounding up keeps each answer no earlier than the processor could give it
  function automatic logic [4:0] cpu_to_sys(input int cpu_cyc);
    int n;
    n = (cpu_cyc + CPU_RATIO - 1) / CPU_RATIO;
    if (n < 1) n = 1;
    return n[4:0];
  endfunction

  // answer delays in system cycles, fixed at elaboration
  localparam logic [4:0] NOACK_CYC = cpu_to_sys(`CPR_NOACK_CPU_CYC);
  localparam logic [4:0] ACK_SC_CYC = cpu_to_sys(`CPR_ACK_SC_CPU_CYC);
  localparam logic [4:0] BC_CYC = cpu_to_sys(`CPR_BC_CPU_CYC);
  localparam logic [1:0] LAST_BEAT = 2'(`CPR_BEATS - 1);

  // parameter values the logic cannot serve stop elaboration
  // the ratio bound keeps every delay inside the five-bit counter
  if (CPU_RATIO < 1 || CPU_RATIO > 8) $error("processor clock ratio out of range");
  if (RES_NOACK == RES_ACK_SC || RES_NOACK == RES_ACK_BC || RES_ACK_SC == RES_ACK_BC)
    $error("acknowledge codes must differ");
  if (ADDR_W < 4) $error("address too narrow");

  cpr_stream_if #(.W(4 + ADDR_W)) cmd_in_s ();
  cpr_stream_if #(.W(4 + ADDR_W)) cmd_q_s ();
  cpr_stream_if #(.W(`CPR_BEAT_W)) beat_in_s ();
  cpr_stream_if #(.W(`CPR_BEAT_W)) beat_out_s ();

  // sequencer state and the command being served
  cpr_pkg::cpr_state_t state_ff;
  cpr_pkg::cpr_state_t nxt_state;
  logic [3:0] cur_cmd_ff;
  logic [ADDR_W-1:0] cur_addr_ff;
  // probe outcome, latched for the whole command
  logic hit_ff;
  logic dirty_ff;
  logic present_ff;
  logic [1:0] code_ff;
  logic [4:0] target_ff;
  logic [4:0] cnt_ff;
  // beat counters: pushed into the buffer and taken by the system
  logic [1:0] push_beat_ff;
  logic [1:0] sent_beat_ff;
  logic overflow_ff;
  logic probe_ff;
  logic [1:0] sc_op_ff;
  logic res_valid_ff;
  logic [2:0] res_ff;
  logic bc_rd_ff;
  logic bc_dwr_ff;
  logic [1:0] bc_beat_ff;
  logic bc_tag_wr_ff;
  logic [1:0] bc_tag_ff;
  // decodes of the command being served
  logic is_read;
  logic is_rdi;
  logic answer_now;
  logic dack_beat;

  // two-entry command queue; a command is only taken while the system owns the bus
  cpr_buf2 #(.W(4 + ADDR_W)) u_cmd_q (.clk(clk), .rst_b(rst_b), .up(cmd_in_s), .dn(cmd_q_s));
  assign cmd_in_s.valid = !dev_owns_cmd_bus && (sys_cmd != `CPR_CMD_NOP);
  assign cmd_in_s.data = {sys_cmd, sys_addr};
  assign cmd_q_s.ready = (state_ff == cpr_pkg::CPR_IDLE);

  // outgoing beats pass a two-entry buffer so a slow dack loses nothing
  // dack both takes the standing beat and frees a buffer entry
  cpr_buf2 #(.W(`CPR_BEAT_W)) u_beat_q (.clk(clk), .rst_b(rst_b), .up(beat_in_s), .dn(beat_out_s));
  assign beat_out_s.ready = dack;
  assign data_valid = beat_out_s.valid;
  assign data_out = beat_out_s.data;

  assign is_read = (cur_cmd_ff == `CPR_CMD_READ_DIRTY) || (cur_cmd_ff == `CPR_CMD_READ_DIRTY_INV);
  assign is_rdi = (cur_cmd_ff == `CPR_CMD_READ_DIRTY_INV);
  assign answer_now = (state_ff == cpr_pkg::CPR_WAIT) && (cnt_ff >= target_ff);
  assign dack_beat = beat_out_s.valid && dack;

  // first beat is pushed with the answer so it appears on the answer edge
  always_comb begin
    beat_in_s.valid = 1'b0;
    if (answer_now && is_read && hit_ff && dirty_ff) beat_in_s.valid = 1'b1;
    if (state_ff == cpr_pkg::CPR_SC_DATA && push_beat_ff != 2'h0) beat_in_s.valid = 1'b1;
  end
  assign beat_in_s.data = sc_rd_data;

  // the device never issues its own commands here, so it drives idle while owning
  // the enable lags ownership by one cycle, which the system must allow for
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dev_cmd_out <= `CPR_CMD_NOP;
      dev_cmd_oe_b <= 1'b1;
    end else begin
      dev_cmd_out <= `CPR_CMD_NOP;
      dev_cmd_oe_b <= !dev_owns_cmd_bus;
    end
  end

  // sticky flag for a command offered while both queue entries are taken
  // the command itself is lost; the flag only exposes a system that paces badly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) overflow_ff <= 1'b0;
    else if (cmd_in_s.valid && !cmd_in_s.ready) overflow_ff <= 1'b1;
  end
  assign cmd_overflow = overflow_ff;

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cpr_pkg::CPR_IDLE: if (cmd_q_s.valid) nxt_state = cpr_pkg::CPR_PROBE;
      cpr_pkg::CPR_PROBE: nxt_state = cpr_pkg::CPR_WAIT;
      cpr_pkg::CPR_WAIT: begin
        if (answer_now) begin
          if (is_read && hit_ff && dirty_ff) nxt_state = cpr_pkg::CPR_SC_DATA;
          else if (is_read && !hit_ff && bcache_present) nxt_state = cpr_pkg::CPR_BC_DATA;
          // invalidate, set shared and reads with nothing to send end with their answer
          else nxt_state = cpr_pkg::CPR_IDLE;
        end
      end
      cpr_pkg::CPR_SC_DATA:
        if (dack_beat && sent_beat_ff == LAST_BEAT) nxt_state = cpr_pkg::CPR_IDLE;
      cpr_pkg::CPR_BC_DATA:
        if (dack && bc_beat_ff == LAST_BEAT) nxt_state = cpr_pkg::CPR_IDLE;
      default: nxt_state = cpr_pkg::CPR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_ff <= cpr_pkg::CPR_IDLE;
    else state_ff <= nxt_state;
  end

  // take the queued command and start the second-level probe
  // the probe address stays put until the next command is taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_cmd_ff <= `CPR_CMD_NOP;
      cur_addr_ff <= '0;
      probe_ff <= 1'b0;
    end else begin
      probe_ff <= 1'b0;
      if (state_ff == cpr_pkg::CPR_IDLE && cmd_q_s.valid) begin
        cur_cmd_ff <= cmd_q_s.data[ADDR_W +: 4];
        cur_addr_ff <= cmd_q_s.data[ADDR_W-1:0];
        probe_ff <= 1'b1;
      end
    end
  end
  assign sc_probe = probe_ff;
  assign probe_addr = cur_addr_ff;

  // probe results are sampled at the end of the probe pulse cycle; pick code and delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_ff <= 1'b0;
      dirty_ff <= 1'b0;
      present_ff <= 1'b0;
      code_ff <= RES_NOACK;
      target_ff <= NOACK_CYC;
    end else if (state_ff == cpr_pkg::CPR_PROBE) begin
      hit_ff <= sc_hit;
      dirty_ff <= sc_dirty;
      present_ff <= sc_hit || lock_hit;
      target_ff <= bcache_present ? BC_CYC : NOACK_CYC;
      if (cur_cmd_ff == `CPR_CMD_INVAL || cur_cmd_ff == `CPR_CMD_SET_SHARED) begin
        if (!bcache_present && sc_hit) begin
          code_ff <= RES_ACK_SC;
          target_ff <= ACK_SC_CYC;
        end else if (bcache_present) begin
          code_ff <= (sc_hit && cur_cmd_ff == `CPR_CMD_SET_SHARED) ? RES_ACK_SC : RES_ACK_BC;
        end else begin
          code_ff <= RES_NOACK;
        end
      end else if (sc_hit && sc_dirty) begin
        code_ff <= RES_ACK_SC;
        if (!bcache_present) target_ff <= ACK_SC_CYC;
      end else if (!sc_hit && bcache_present) begin
        code_ff <= RES_ACK_BC;
      end else begin
        code_ff <= RES_NOACK;
      end
    end
  end

  // response delay counted from the cycle the command left the queue
  // counting from the pop keeps the delay the same whether the queue was full or not
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_ff <= 5'h0;
    else if (state_ff == cpr_pkg::CPR_IDLE) cnt_ff <= 5'h1;
    else if (state_ff == cpr_pkg::CPR_PROBE || state_ff == cpr_pkg::CPR_WAIT) cnt_ff <= cnt_ff + 5'h1;
  end

  // response pulse; the code itself holds until the next answer
  // the presence bit needs no strobe of its own, it travels in the held code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid_ff <= 1'b0;
      res_ff <= `CPR_RES_RST;
    end else begin
      res_valid_ff <= answer_now;
      if (answer_now) res_ff <= {present_ff, code_ff};
    end
  end
  assign res_valid = res_valid_ff;
  assign addr_res = res_ff;

  // second-level read beat index: one beat ahead of what has been pushed
  // it wraps to zero after the last push, which also stops further pushes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) push_beat_ff <= 2'h0;
    else if (state_ff == cpr_pkg::CPR_IDLE) push_beat_ff <= 2'h0;
    else if (beat_in_s.valid && beat_in_s.ready) push_beat_ff <= push_beat_ff + 2'h1;
  end
  assign sc_rd_beat = push_beat_ff;

  // beats taken by the system, counted on each data acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sent_beat_ff <= 2'h0;
    else if (state_ff == cpr_pkg::CPR_IDLE) sent_beat_ff <= 2'h0;
    else if (state_ff == cpr_pkg::CPR_SC_DATA && dack_beat) sent_beat_ff <= sent_beat_ff + 2'h1;
  end

  // second-level state update issued with the answer
  // a clean hit on a read needs no update, the line stays as it is
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sc_op_ff <= cpr_pkg::CPR_SC_NONE;
    else begin
      sc_op_ff <= cpr_pkg::CPR_SC_NONE;
      if (answer_now && hit_ff) begin
        if (cur_cmd_ff == `CPR_CMD_INVAL) sc_op_ff <= cpr_pkg::CPR_SC_INVAL;
        else if (cur_cmd_ff == `CPR_CMD_SET_SHARED) sc_op_ff <= cpr_pkg::CPR_SC_SHARE;
        else if (is_read && dirty_ff) sc_op_ff <= is_rdi ? cpr_pkg::CPR_SC_INVAL : cpr_pkg::CPR_SC_SHARE;
      end
    end
  end
  assign sc_upd_op = sc_op_ff;

  // board cache read: indexed at the answer, advanced by each dack
  // a second-level read steps the same index so each board data copy lands per beat
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bc_rd_ff <= 1'b0;
      bc_beat_ff <= 2'h0;
    end else if (answer_now && is_read && !hit_ff && bcache_present) begin
      bc_rd_ff <= 1'b1;
      bc_beat_ff <= 2'h0;
    end else if (state_ff == cpr_pkg::CPR_BC_DATA && dack) begin
      bc_beat_ff <= bc_beat_ff + 2'h1;
      if (bc_beat_ff == LAST_BEAT) bc_rd_ff <= 1'b0;
    end else if (state_ff == cpr_pkg::CPR_SC_DATA && dack_beat) begin
      bc_beat_ff <= bc_beat_ff + 2'h1;
    end else if (state_ff == cpr_pkg::CPR_IDLE) begin
      bc_beat_ff <= 2'h0;
    end
  end
  assign bc_rd_en = bc_rd_ff;
  assign bc_index = {cur_addr_ff, bc_beat_ff};

  // board data copy of each second-level beat as the system takes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) bc_dwr_ff <= 1'b0;
    else bc_dwr_ff <= bcache_present && state_ff == cpr_pkg::CPR_SC_DATA && dack_beat;
  end
  assign bc_data_wr = bc_dwr_ff;

  // board tag writes: immediate for invalidate and set shared, second beat for reads
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bc_tag_wr_ff <= 1'b0;
      bc_tag_ff <= cpr_pkg::CPR_TAG_INVALID;
    end else begin
      bc_tag_wr_ff <= 1'b0;
      if (answer_now && bcache_present && cur_cmd_ff == `CPR_CMD_INVAL) begin
        bc_tag_wr_ff <= 1'b1;
        bc_tag_ff <= cpr_pkg::CPR_TAG_INVALID;
      end else if (answer_now && bcache_present && cur_cmd_ff == `CPR_CMD_SET_SHARED) begin
        bc_tag_wr_ff <= 1'b1;
        bc_tag_ff <= cpr_pkg::CPR_TAG_SHARED;
      end else if (bcache_present && is_read && bc_beat_ff == `CPR_TAG_BEAT - 2'h1 &&
                   ((state_ff == cpr_pkg::CPR_BC_DATA && dack) ||
                    (state_ff == cpr_pkg::CPR_SC_DATA && dack_beat))) begin
        // the pulse lands on the edge that steps the index to the second beat; keyed to
        // that step alone, so a tag that already holds the new state is written again
        bc_tag_wr_ff <= 1'b1;
        bc_tag_ff <= is_rdi ? cpr_pkg::CPR_TAG_INVALID : cpr_pkg::CPR_TAG_SHARED_DIRTY;
      end
    end
  end
  assign bc_tag_wr = bc_tag_wr_ff;
  assign bc_tag_state = bc_tag_ff;
endmodule

// ### hw/cpr_buf2.sv
// two-entry buffer: an output word register plus one skid word
// assumes the drain side may hold ready low for any number of cycles
module cpr_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  cpr_stream_if.snk up,
  cpr_stream_if.src dn
);
  logic out_v_ff;
  logic skid_v_ff;
  logic [W-1:0] out_d_ff;
  logic [W-1:0] skid_d_ff;
  logic push;
  logic pop;

  // a zero-width buffer has nothing to hold
  if (W < 1) $error("buffer width must be positive");

  // ready depends only on the skid flop, so the source never sees a loop
  assign up.ready = !skid_v_ff;
  assign dn.valid = out_v_ff;
  assign dn.data = out_d_ff;
  assign push = up.valid && !skid_v_ff;
  assign pop = out_v_ff && dn.ready;

  // output register refills from the skid word first to keep order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_v_ff <= 1'b0;
      out_d_ff <= '0;
    end else if (!out_v_ff || pop) begin
      if (skid_v_ff) begin
        out_v_ff <= 1'b1;
        out_d_ff <= skid_d_ff;
      end else begin
        out_v_ff <= push;
        if (push) out_d_ff <= up.data;
      end
    end
  end

  // skid word catches a push while the output register is stalled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      skid_v_ff <= 1'b0;
      skid_d_ff <= '0;
    end else if (skid_v_ff) begin
      if (!out_v_ff || pop) skid_v_ff <= 1'b0;
    end else if (push && out_v_ff && !pop) begin
      skid_v_ff <= 1'b1;
      skid_d_ff <= up.data;
    end
  end
endmodule

// ### hw/cpr_defines.svh
// constants of the coherence probe responder: command codes, timing, beats
// assumes inclusion by bare name from any design file that needs them
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH

// system command codes on the four command lines
`define CPR_CMD_NOP 4'h0
`define CPR_CMD_INVAL 4'h2
`define CPR_CMD_SET_SHARED 4'h3
`define CPR_CMD_READ_DIRTY 4'h5
`define CPR_CMD_READ_DIRTY_INV 4'h7

// earliest response times, in processor cycles
`define CPR_NOACK_CPU_CYC 8
`define CPR_ACK_SC_CPU_CYC 12
`define CPR_BC_CPU_CYC 10

// one line is four sixteen-byte beats
`define CPR_BEATS 4
`define CPR_BEAT_W 128
// the board tag is written during the second beat
`define CPR_TAG_BEAT 2'h1

// response field positions
`define CPR_RES_PRESENT_BIT 2

// reset values of driven outputs
`define CPR_RES_RST 3'h0

`endif

// ### hw/cpr_pkg.sv
// types shared by the coherence probe responder modules
// assumes nothing beyond a SystemVerilog compiler
package cpr_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    CPR_IDLE = 3'b000,
    CPR_PROBE = 3'b001,
    CPR_WAIT = 3'b010,
    CPR_SC_DATA = 3'b011,
    CPR_BC_DATA = 3'b100
  } cpr_state_t;

  // board cache tag states written back
  typedef enum logic [1:0] {
    CPR_TAG_INVALID = 2'b00,
    CPR_TAG_SHARED = 2'b01,
    CPR_TAG_SHARED_DIRTY = 2'b10
  } cpr_tag_t;

  // second-level cache state updates
  typedef enum logic [1:0] {
    CPR_SC_NONE = 2'b00,
    CPR_SC_INVAL = 2'b01,
    CPR_SC_SHARE = 2'b10
  } cpr_sc_op_t;

endpackage

// ### hw/cpr_stream_if.sv
// valid/ready word carrier between the responder and its two-entry buffers
// assumes both ends share one clock
interface cpr_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### testbench/cpr_checker_properties.sv
// port assertions for the coherence probe responder
// assumes one clock domain; bound to the top module below
module cpr_checker #(
  parameter int ADDR_W = 36,
  parameter logic [1:0] RES_ACK_SC = 2'h1,
  parameter logic [1:0] RES_ACK_BC = 2'h2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dev_owns_cmd_bus,
  input wire logic dack,
  input wire logic [3:0] dev_cmd_out,
  input wire logic dev_cmd_oe_b,
  input wire logic cmd_overflow,
  input wire logic sc_probe,
  input wire logic [1:0] sc_upd_op,
  input wire logic res_valid,
  input wire logic [2:0] addr_res,
  input wire logic data_valid,
  input wire logic [127:0] data_out,
  input wire logic bc_rd_en,
  input wire logic [ADDR_W+1:0] bc_index,
  input wire logic bc_tag_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] beat_lo;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // beat part of the board index
  assign beat_lo = bc_index[1:0];

  // a probe ends in a single answer pulse
  sequence s_probe;
    sc_probe;
  endsequence
  sequence s_answer;
    res_valid ##1 !res_valid;
  endsequence

  a_idle_cmd_code: assert property (dev_cmd_out == 4'h0)
    else $error("non-idle command driven");
  a_oe_tracks_owner: assert property (dev_cmd_oe_b == !$past(dev_owns_cmd_bus))
    else $error("command enable wrong for bus owner");
  a_overflow_sticky: assert property ($past(cmd_overflow) |-> cmd_overflow)
    else $error("overflow flag cleared");
  a_probe_to_answer: assert property (s_probe |-> ##[4:6] s_answer)
    else $error("answer not in window after probe");
  a_update_at_answer: assert property (sc_upd_op != 2'h0 |-> res_valid)
    else $error("cache update away from answer");
  a_result_held: assert property (!res_valid |-> $stable(addr_res))
    else $error("answer changed without pulse");
  a_data_with_ack: assert property ($rose(data_valid) |-> res_valid && addr_res[1:0] == RES_ACK_SC)
    else $error("data started off the answer edge");
  a_beat_stands: assert property (data_valid && !dack |=> data_valid && $stable(data_out))
    else $error("beat dropped before dack");
  a_board_start: assert property ($rose(bc_rd_en) |-> res_valid && addr_res[1:0] == RES_ACK_BC)
    else $error("board read off the answer edge");
  a_board_advance: assert property (bc_rd_en && dack |=> !bc_rd_en || beat_lo == $past(beat_lo) + 2'h1)
    else $error("board index did not advance");
  a_tag_second_beat: assert property (bc_tag_wr && bc_rd_en |-> beat_lo == 2'h1)
    else $error("board tag written off second beat");
endmodule

bind coherence_probe_responder cpr_checker #(
  .ADDR_W(ADDR_W), .RES_ACK_SC(RES_ACK_SC), .RES_ACK_BC(RES_ACK_BC)
) u_chk (
  .clk, .rst_b, .dev_owns_cmd_bus, .dack, .dev_cmd_out, .dev_cmd_oe_b, .cmd_overflow,
  .sc_probe, .sc_upd_op, .res_valid, .addr_res, .data_valid, .data_out, .bc_rd_en,
  .bc_index, .bc_tag_wr
);

// ### testbench/cpr_sys_model.sv
// system controller model: sends commands and paces beats with dack
// assumes the bench calls its tasks and sets stall_cyc
module cpr_sys_model #(
  parameter int ADDR_W = 36
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic beat_pending,
  output logic [3:0] sys_cmd,
  output logic [ADDR_W-1:0] sys_addr,
  output logic dev_owns_cmd_bus,
  output logic dack
);
  timeunit 1ns;
  timeprecision 100ps;
  int stall_cyc = 0;
  int wait_cnt;

  // system holds the bus and idles it until it has work
  initial begin
    sys_cmd = 4'h0;
    sys_addr = '1;
    dev_owns_cmd_bus = 1'b0;
  end

  // one command per cycle; the idle code and a changed address follow
  task automatic send_burst(input logic [3:0] cmd, input logic [ADDR_W-1:0] addr, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sys_cmd <= cmd;
      sys_addr <= addr + ADDR_W'(i);
    end
    @(posedge clk);
    sys_cmd <= 4'h0;
    sys_addr <= ~sys_addr;
  endtask

  // hands the command bus over; commands sent then break ownership on purpose
  task automatic grant(input logic own);
    @(posedge clk);
    dev_owns_cmd_bus <= own;
  endtask

  // one dack pulse per offered beat after stall_cyc plus one idle cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dack <= 1'b0;
      wait_cnt <= 0;
    end else if (dack || !beat_pending) begin
      dack <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt >= stall_cyc) begin
      dack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ### testbench/test_coherence_probe_responder.sv
// self-checking bench for the coherence probe responder
// assumes the system model drives commands and dack; the bench drives probe results
`include "cpr_defines.svh"
module test_coherence_probe_responder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bcache_present = 1'b0;
  logic sc_hit = 1'b0;
  logic sc_dirty = 1'b0;
  logic lock_hit = 1'b0;
  logic [3:0] sys_cmd, dev_cmd_out;
  logic [35:0] sys_addr, probe_addr;
  logic dev_owns_cmd_bus, dack, dev_cmd_oe_b, cmd_overflow, sc_probe, res_valid, data_valid;
  logic bc_rd_en, bc_data_wr, bc_tag_wr, dv_ans;
  logic [1:0] sc_rd_beat, sc_upd_op, bc_tag_state, tag_st, got_upd;
  logic [2:0] addr_res, got_res;
  logic [127:0] sc_rd_data, data_out;
  logic [37:0] bc_index;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int lat, res_n, beat_n, tag_n, wr_n;

  // each beat carries its own index so a skipped beat shows
  function automatic logic [127:0] pat(input logic [1:0] b);
    pat = {4{30'h2AAA_AAAA, b}};
  endfunction
  assign sc_rd_data = pat(sc_rd_beat);

  always #2 clk = ~clk;

  // cycle ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  coherence_probe_responder u_dut (
    .clk, .rst_b, .sys_cmd, .sys_addr, .dev_owns_cmd_bus, .dack, .bcache_present, .sc_hit,
    .sc_dirty, .lock_hit, .sc_rd_data, .dev_cmd_out, .dev_cmd_oe_b, .cmd_overflow, .sc_probe,
    .probe_addr, .sc_rd_beat, .sc_upd_op, .res_valid, .addr_res, .data_valid, .data_out,
    .bc_rd_en, .bc_data_wr, .bc_index, .bc_tag_wr, .bc_tag_state
  );
  cpr_sys_model u_sys (
    .clk, .rst_b, .beat_pending(data_valid | bc_rd_en), .sys_cmd, .sys_addr, .dev_owns_cmd_bus, .dack
  );

  task automatic chk_v(input logic [127:0] got, input logic [127:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic cache(input logic b, input logic h, input logic d, input logic l);
    @(posedge clk);
    bcache_present <= b;
    sc_hit <= h;
    sc_dirty <= d;
    lock_hit <= l;
  endtask

  // sends n commands, then records answers, beats and tag writes for 48 cycles
  task automatic run(input logic [3:0] cmd, input int n);
    lat = 0;
    res_n = 0;
    beat_n = 0;
    tag_n = 0;
    wr_n = 0;
    tag_st = 2'h3;
    dv_ans = 1'b0;
    u_sys.send_burst(cmd, 36'h0_ABCD_0120, n);
    for (int k = 1; k <= 48; k++) begin
      @(posedge clk);
      #1;
      if (res_valid === 1'b1) begin
        res_n++;
        if (lat == 0) begin
          lat = k;
          got_res = addr_res;
          got_upd = sc_upd_op;
          dv_ans = data_valid;
        end
      end
      if (bc_tag_wr === 1'b1) begin
        tag_n++;
        tag_st = bc_tag_state;
      end
      if (bc_data_wr === 1'b1) wr_n++;
      if (dack === 1'b1 && data_valid === 1'b1) begin
        chk_v(data_out, pat(beat_n[1:0]), "beat data");
        beat_n++;
      end
      if (dack === 1'b1 && bc_rd_en === 1'b1) begin
        chk_v(bc_index[1:0], beat_n[1:0], "board index");
        beat_n++;
      end
    end
  endtask

  // lat counts edges from the take; the pop is one edge later and t counts from the pop
  task automatic expect_ans(input logic [2:0] res, input int t);
    chk_v(got_res, res, "answer code");
    chk_n(lat, t + 1, "answer cycles");
  endtask

  task automatic t_inval;
    cache(1'b0, 1'b1, 1'b1, 1'b0);
    run(`CPR_CMD_INVAL, 1);
    expect_ans(3'h5, 6);
    chk_v(got_upd, 2'h1, "line dropped");
    chk_v(probe_addr, 36'h0_ABCD_0120, "probe address");
    chk_n(beat_n + int'(dv_ans), 0, "dirty data sent");
    cache(1'b0, 1'b0, 1'b0, 1'b0);
    run(`CPR_CMD_INVAL, 1);
    expect_ans(3'h0, 4);
    cache(1'b1, 1'b0, 1'b0, 1'b1);
    run(`CPR_CMD_INVAL, 1);
    expect_ans(3'h6, 5);
    chk_v(tag_st, 2'h0, "tag invalid");
    $display("invalidate test done");
  endtask

  task automatic t_share;
    cache(1'b0, 1'b0, 1'b0, 1'b0);
    run(`CPR_CMD_SET_SHARED, 1);
    expect_ans(3'h0, 4);
    cache(1'b0, 1'b1, 1'b0, 1'b0);
    run(`CPR_CMD_SET_SHARED, 1);
    expect_ans(3'h5, 6);
    chk_v(got_upd, 2'h2, "line shared");
    cache(1'b1, 1'b0, 1'b0, 1'b0);
    run(`CPR_CMD_SET_SHARED, 1);
    expect_ans(3'h2, 5);
    chk_n(tag_n, 1, "tag writes");
    chk_v(tag_st, 2'h1, "tag shared");
    $display("set shared test done");
  endtask

  task automatic t_rd_sc;
    u_sys.stall_cyc = 3;
    cache(1'b0, 1'b1, 1'b1, 1'b0);
    run(`CPR_CMD_READ_DIRTY, 1);
    expect_ans(3'h5, 6);
    chk_v(dv_ans, 1'b1, "data with answer");
    chk_v(got_upd, 2'h2, "line left shared");
    chk_n(beat_n, 4, "beats");
    cache(1'b0, 1'b1, 1'b0, 1'b0);
    run(`CPR_CMD_READ_DIRTY, 1);
    expect_ans(3'h4, 4);
    chk_n(beat_n, 0, "clean beats");
    $display("read dirty cache test done");
  endtask

  task automatic t_rd_bc;
    u_sys.stall_cyc = 1;
    cache(1'b1, 1'b0, 1'b0, 1'b0);
    run(`CPR_CMD_READ_DIRTY, 1);
    expect_ans(3'h2, 5);
    chk_n(beat_n, 4, "board beats");
    chk_v(bc_rd_en, 1'b0, "board read ends");
    chk_v(tag_st, 2'h2, "tag shared dirty");
    run(`CPR_CMD_READ_DIRTY_INV, 1);
    expect_ans(3'h2, 5);
    chk_v(tag_st, 2'h0, "tag invalid");
    cache(1'b1, 1'b1, 1'b1, 1'b0);
    run(`CPR_CMD_READ_DIRTY_INV, 1);
    expect_ans(3'h5, 5);
    chk_n(wr_n, 4, "board data writes");
    chk_v(got_upd, 2'h1, "line dropped on read");
    chk_v(tag_st, 2'h0, "tag invalid");
    $display("read dirty board test done");
  endtask

  task automatic t_flow;
    cache(1'b0, 1'b0, 1'b0, 1'b0);
    u_sys.grant(1'b1);
    run(`CPR_CMD_INVAL, 1);
    chk_n(res_n, 0, "answer while device owns bus");
    chk_v(dev_cmd_oe_b, 1'b0, "device drives bus");
    u_sys.grant(1'b0);
    run(`CPR_CMD_INVAL, 4);
    chk_n(res_n, 3, "answers to burst");
    chk_v(cmd_overflow, 1'b1, "overflow seen");
    $display("flow test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_inval();
    t_share();
    t_rd_sc();
    t_rd_bc();
    t_flow();
    report_and_stop();
  end
endmodule
